// ### rtl/scs_defs.svh
// Constants of the scan channel sequencer: widths, defaults and timing counts
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ==========================================================
// Time base
`define SCS_CLK_NS 10
`define SCS_TICK_NS 1000000
`define SCS_TICK_CYCLES (`SCS_TICK_NS / `SCS_CLK_NS)
`define SCS_TICK_W 20

// ==========================================================
// Field widths
`define SCS_LIST_AW 6
`define SCS_LEN_W 7
`define SCS_CH_W 7
`define SCS_SLOT_W 2
`define SCS_NSLOT 4
`define SCS_DELAY_W 14
`define SCS_PW_W 7
`define SCS_FILT_W 10
`define SCS_COMM_W 4

// ==========================================================
// Defaults and limits
`define SCS_PW_MIN_MS 7'h01
`define SCS_PW_MAX_MS 7'h64
`define SCS_PW_DEF_MS 7'h05
`define SCS_DELAY_DEF_MS 14'h0000
`define SCS_FILT_DEF_MS 10'h032
`define SCS_COMM_DEF 4'h0
`define SCS_LEN_DEF 7'h00

`endif

// ### rtl/scs_pkg.sv
// Types shared by the scan channel sequencer and its list memory
package scs_pkg;
`include "scs_defs.svh"

	typedef enum logic [1:0] {
		PW_VALUE = 2'h0,
		PW_MIN = 2'h1,
		PW_MAX = 2'h2,
		PW_DEF = 2'h3
	} scs_pw_sel_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOAD = 5'h02,
		ST_DELAY = 5'h04,
		ST_PULSE = 5'h08,
		ST_WAIT = 5'h10
	} scs_state_type;

	// One command per field group; several may be valid in one cycle
	typedef struct packed {
		logic trg;
		logic abort;
		logic init;
		logic backup;
		logic wr_conn;
		logic conn;
		logic wr_shield;
		logic shield;
		logic wr_delay;
		logic [`SCS_SLOT_W-1:0] slot;
		logic [`SCS_DELAY_W-1:0] delay_ms;
		logic wr_list;
		logic [`SCS_LIST_AW-1:0] list_idx;
		logic [`SCS_CH_W-1:0] list_chan;
		logic wr_len;
		logic [`SCS_LEN_W-1:0] len;
		logic wr_pulse;
		scs_pw_sel_type pw_sel;
		logic [`SCS_PW_W-1:0] pw_ms;
		logic wr_filter;
		logic filt_en;
		logic [`SCS_FILT_W-1:0] filt_ms;
		logic wr_close;
		logic close_en;
		logic [`SCS_CH_W-1:0] close_chan;
		logic wr_comm;
		logic [`SCS_COMM_W-1:0] comm;
	} scs_cmd_type;

	typedef struct packed {
		logic conn;
		logic shield;
		logic [`SCS_NSLOT-1:0][`SCS_DELAY_W-1:0] delay_ms;
		logic [`SCS_LEN_W-1:0] list_len;
		logic [`SCS_PW_W-1:0] pw_ms;
		logic filt_en;
		logic [`SCS_FILT_W-1:0] filt_ms;
		logic [`SCS_COMM_W-1:0] comm;
	} scs_settings_type;

	typedef struct packed {
		logic scan_active;
		logic relay_closed;
		logic [`SCS_CH_W-1:0] chan;
		logic [`SCS_LIST_AW-1:0] ptr;
		logic reject;
		logic backup_wr;
		logic comm_wr;
	} scs_status_type;
endpackage : scs_pkg

// ### rtl/scs_list_mem.sv
// Scan list table with one write port and a registered read port
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_list_mem import scs_pkg::*; #(
	parameter int AW = `SCS_LIST_AW,
	parameter int DW = `SCS_CH_W
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	typedef struct packed {
		logic [(1<<AW)-1:0][DW-1:0] mem;
		logic [DW-1:0] rd;
	} scs_mem_state_type;

	scs_mem_state_type q;
	scs_mem_state_type d;

	always_comb begin
		d = q;
		d.rd = q.mem[rd_addr];
		if (wr_en) begin
			d.mem[wr_addr] = wr_data;
		end
	end

	// No reset: contents only count up to the list length, which resets to zero
	always_ff @(posedge clk) begin
		if (ce) begin
			q <= d;
		end
	end

	assign rd_data = q.rd;
endmodule : scs_list_mem

// ### rtl/scs_sequencer.sv
// Scan channel sequencer: steps relays through a scan list on triggers
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_sequencer import scs_pkg::*; #(
	parameter int TICK_CYCLES = `SCS_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic scan_adv_pin,
	input wire logic scan_reset_pin,
	input wire scs_cmd_type cmd,
	output logic close_out,
	output scs_status_type status,
	output scs_settings_type settings
);
	// ==========================================================
	// State
	typedef struct packed {
		scs_settings_type set;
		scs_state_type st;
		logic [`SCS_LIST_AW-1:0] ptr;
		logic [`SCS_CH_W-1:0] chan;
		logic closed;
		logic close_out;
		logic [`SCS_DELAY_W-1:0] cnt;
		logic [`SCS_TICK_W-1:0] tick_cnt;
		logic tick;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] flt;
		logic [1:0][`SCS_FILT_W-1:0] flt_cnt;
		logic reject;
		logic backup_wr;
		logic comm_wr;
		logic act;
	} scs_seq_state_type;

	scs_seq_state_type q;
	scs_seq_state_type d;
	logic [`SCS_CH_W-1:0] rd_chan;
	logic adv_pin;
	logic adv_ev;
	logic stop_ev;
	logic active;
	logic locked_wr;
	logic last;

	// Defaults shared by power-up and command initialisation
	function automatic scs_settings_type scs_defaults(input logic [`SCS_COMM_W-1:0] comm);
		scs_settings_type s;
		s.conn = 1'b0;
		s.shield = 1'b0;
		s.delay_ms = '0;
		for (int i = 0; i < `SCS_NSLOT; i++) begin
			s.delay_ms[i] = `SCS_DELAY_DEF_MS;
		end
		s.list_len = `SCS_LEN_DEF;
		s.pw_ms = `SCS_PW_DEF_MS;
		s.filt_en = 1'b0;
		s.filt_ms = `SCS_FILT_DEF_MS;
		s.comm = comm;
		return s;
	endfunction : scs_defaults

	localparam scs_seq_state_type RST_VAL = '{
		set: scs_defaults(`SCS_COMM_DEF),
		st: ST_IDLE,
		default: '0
	};

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		d.reject = 1'b0;
		d.backup_wr = 1'b0;
		d.comm_wr = 1'b0;
		d.tick = 1'b0;
		d.s1 = {scan_reset_pin, scan_adv_pin};
		d.s2 = q.s1;

		// Free-running 1 ms time base
		if (q.tick_cnt == `SCS_TICK_W'(TICK_CYCLES - 1)) begin
			d.tick_cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + `SCS_TICK_W'(1);
		end

		// Input filter: a new level must stand for the filter time
		for (int i = 0; i < 2; i++) begin
			if (!q.set.filt_en) begin
				d.flt[i] = q.s2[i];
				d.flt_cnt[i] = '0;
			end else if (q.s2[i] == q.flt[i]) begin
				d.flt_cnt[i] = '0;
			end else if (q.tick) begin
				if (q.flt_cnt[i] + `SCS_FILT_W'(1) >= q.set.filt_ms) begin
					d.flt[i] = q.s2[i];
					d.flt_cnt[i] = '0;
				end else begin
					d.flt_cnt[i] = q.flt_cnt[i] + `SCS_FILT_W'(1);
				end
			end
		end

		active = q.st != ST_IDLE;
		last = {1'b0, q.ptr} + `SCS_LEN_W'(1) >= q.set.list_len;
		// Advance pin edges count only when no channel switch is under way; a trg command counts in every state but ST_LOAD
		adv_pin = d.flt[0] & ~q.flt[0] & (q.st != ST_LOAD) & (q.st != ST_DELAY);
		adv_ev = (cmd.trg & (q.st != ST_LOAD)) | adv_pin;
		stop_ev = (d.flt[1] & ~q.flt[1]) | cmd.abort | cmd.init;
		locked_wr = cmd.wr_conn | cmd.wr_shield | cmd.wr_delay | cmd.wr_list | cmd.wr_len
			| cmd.wr_pulse | cmd.wr_filter | cmd.wr_close;

		// ==========================================================
		// Setting commands
		if (active && locked_wr) begin
			d.reject = 1'b1;
		end else begin
			if (cmd.wr_conn) begin
				d.set.conn = cmd.conn;
			end
			if (cmd.wr_shield) begin
				d.set.shield = cmd.shield;
			end
			if (cmd.wr_delay) begin
				d.set.delay_ms[cmd.slot] = cmd.delay_ms;
			end
			if (cmd.wr_len) begin
				d.set.list_len = cmd.len;
			end
			if (cmd.wr_filter) begin
				d.set.filt_en = cmd.filt_en;
				d.set.filt_ms = cmd.filt_ms;
			end
			if (cmd.wr_pulse) begin
				case (cmd.pw_sel)
					PW_MIN: d.set.pw_ms = `SCS_PW_MIN_MS;
					PW_MAX: d.set.pw_ms = `SCS_PW_MAX_MS;
					PW_DEF: d.set.pw_ms = `SCS_PW_DEF_MS;
					default: begin
						if (cmd.pw_ms < `SCS_PW_MIN_MS) begin
							d.set.pw_ms = `SCS_PW_MIN_MS;
						end else if (cmd.pw_ms > `SCS_PW_MAX_MS) begin
							d.set.pw_ms = `SCS_PW_MAX_MS;
						end else begin
							d.set.pw_ms = cmd.pw_ms;
						end
					end
				endcase
			end
			if (cmd.wr_close && !active) begin
				d.chan = cmd.close_chan;
				d.closed = cmd.close_en;
			end
		end
		// Comm settings are stored at once; the rest only on backup
		if (cmd.wr_comm) begin
			d.set.comm = cmd.comm;
			d.comm_wr = 1'b1;
		end
		d.backup_wr = cmd.backup;

		// ==========================================================
		// Scan sequence
		case (q.st)
			ST_IDLE: begin
				if (adv_ev && q.set.list_len != '0) begin
					d.ptr = '0;
					d.closed = 1'b0;
					d.st = ST_LOAD;
				end
			end
			ST_LOAD: begin
				d.chan = rd_chan;
				d.closed = 1'b1;
				d.cnt = '0;
				d.st = ST_DELAY;
			end
			ST_DELAY: begin
				if (q.cnt >= q.set.delay_ms[q.chan[`SCS_CH_W-1 -: `SCS_SLOT_W]]) begin
					d.cnt = '0;
					d.close_out = 1'b1;
					d.st = ST_PULSE;
				end else if (q.tick) begin
					d.cnt = q.cnt + `SCS_DELAY_W'(1);
				end
			end
			ST_PULSE: begin
				if (q.tick) begin
					if (q.cnt + `SCS_DELAY_W'(1) >= `SCS_DELAY_W'(q.set.pw_ms)) begin
						d.close_out = 1'b0;
						d.st = ST_WAIT;
					end else begin
						d.cnt = q.cnt + `SCS_DELAY_W'(1);
					end
				end
			end
			ST_WAIT: begin
				d.st = ST_WAIT;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		if (active && q.st != ST_LOAD && adv_ev) begin
			d.close_out = 1'b0;
			d.closed = 1'b0;
			if (last) begin
				d.ptr = '0;
				d.st = ST_IDLE;
			end else begin
				d.ptr = q.ptr + `SCS_LIST_AW'(1);
				d.st = ST_LOAD;
			end
		end

		// Stop wins over any advance in the same cycle
		if (stop_ev) begin
			d.st = ST_IDLE;
			d.ptr = '0;
			d.closed = 1'b0;
			d.close_out = 1'b0;
			d.cnt = '0;
		end
		if (cmd.init) begin
			d.set = scs_defaults(d.set.comm);
		end
		// Registered copy of the state decode so the status output leaves a flop
		d.act = d.st != ST_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			q <= RST_VAL;
		end else if (ce) begin
			q <= d;
		end
	end

	// ==========================================================
	// Scan list table, read at the pointer about to be used
	scs_list_mem #(
		.AW(`SCS_LIST_AW),
		.DW(`SCS_CH_W)
	) u_list (
		.clk(clk),
		.ce(ce),
		.wr_en(cmd.wr_list && !active),
		.wr_addr(cmd.list_idx),
		.wr_data(cmd.list_chan),
		.rd_addr(d.ptr),
		.rd_data(rd_chan)
	);

	assign close_out = q.close_out;
	assign settings = q.set;
	assign status = '{
		scan_active: q.act,
		relay_closed: q.closed,
		chan: q.chan,
		ptr: q.ptr,
		reject: q.reject,
		backup_wr: q.backup_wr,
		comm_wr: q.comm_wr
	};
endmodule : scs_sequencer

// ### verification/scs_sequencer_props.sv
// Port checks of the scan channel sequencer
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_sequencer_props import scs_pkg::*; #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic scan_adv_pin,
	input wire logic scan_reset_pin,
	input wire scs_cmd_type cmd,
	input wire logic close_out,
	input wire scs_status_type status,
	input wire scs_settings_type settings
);
	// ==========================================================
	// Helpers
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [15:0] hi_q;
	logic [3:0] idle_q;
	logic cause;
	assign cause = cmd.trg | cmd.abort | cmd.init | scan_adv_pin | scan_reset_pin;
	// Pins lag by the synchroniser, so a stop may follow its cause by a few cycles
	always_ff @(posedge clk) begin
		hi_q <= close_out ? hi_q + 16'h1 : 16'h0;
		if (!rstn || cause) begin
			idle_q <= 4'h0;
		end else if (idle_q != 4'hF) begin
			idle_q <= idle_q + 4'h1;
		end
	end
	sequence s_start;
		ce && cmd.trg && !cmd.abort && !cmd.init && !status.scan_active
			&& settings.list_len != 7'h00;
	endsequence
	sequence s_step;
		ce && cmd.trg && !cmd.abort && !cmd.init && status.scan_active && status.relay_closed
			&& 7'(status.ptr) + 7'h01 < settings.list_len;
	endsequence
	// ==========================================================
	// Assertions
	a_trg_starts: assert property (s_start |=> status.scan_active ##1
		status.relay_closed && status.ptr == 6'h00) else $error("scan start wrong");
	a_step_next: assert property (s_step |=> !status.relay_closed
		&& status.ptr == $past(status.ptr) + 6'h01 ##1 status.relay_closed)
		else $error("step wrong");
	a_stop_rewinds: assert property ($fell(status.scan_active) |->
		status.ptr == 6'h00 && !status.relay_closed && !close_out) else $error("stop wrong");
	a_no_self_end: assert property ($fell(status.scan_active) |-> idle_q < 4'h8)
		else $error("scan ended alone");
	a_abort_stops: assert property (ce && cmd.abort |=> !status.scan_active
		&& !status.relay_closed && !close_out && status.ptr == 6'h00) else $error("abort");
	a_cut_on_open: assert property (!status.relay_closed |-> !close_out)
		else $error("close without relay");
	a_close_late: assert property ($rose(close_out) |-> status.relay_closed)
		else $error("close early");
	a_width_max: assert property (close_out |-> hi_q < settings.pw_ms * TICK_CYCLES)
		else $error("close too long");
	a_width_min: assert property ($fell(close_out) && status.relay_closed |->
		hi_q >= (settings.pw_ms - 7'h01) * TICK_CYCLES) else $error("close too short");
	a_reject_locked: assert property (ce && status.scan_active && !cmd.abort
		&& !cmd.init && !cmd.wr_comm && (cmd.wr_len | cmd.wr_list | cmd.wr_delay
		| cmd.wr_conn | cmd.wr_shield | cmd.wr_pulse | cmd.wr_filter | cmd.wr_close)
		|=> status.reject && $stable(settings)) else $error("locked write taken");
	a_init_defaults: assert property (ce && cmd.init && !cmd.wr_comm |=>
		settings.pw_ms == `SCS_PW_DEF_MS && !settings.filt_en && settings.list_len == 7'h00
		&& settings.filt_ms == `SCS_FILT_DEF_MS && settings.delay_ms == '0
		&& settings.comm == $past(settings.comm) && !status.scan_active) else $error("init");
endmodule : scs_sequencer_props

bind scs_sequencer scs_sequencer_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
	.clk(clk), .rstn(rstn), .ce(ce), .scan_adv_pin(scan_adv_pin),
	.scan_reset_pin(scan_reset_pin), .cmd(cmd), .close_out(close_out),
	.status(status), .settings(settings));

// ### verification/scs_ctrl_model.sv
// Controller model driving the isolated advance and reset contacts
`timescale 1ns/100ps
module scs_ctrl_model #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic clk,
	output logic adv,
	output logic rst
);
	initial begin
		adv = 1'b0;
		rst = 1'b0;
	end
	// Held past 1 ms so the synchroniser and tick cannot miss it
	task automatic pulse(input logic which);
		@(posedge clk);
		#1;
		adv = !which;
		rst = which;
		repeat (TICK_CYCLES + 2) @(posedge clk);
		#1;
		adv = 1'b0;
		rst = 1'b0;
	endtask : pulse
endmodule : scs_ctrl_model

// ### verification/scs_sequencer_bench.sv
// Self-checking bench of the scan channel sequencer
`timescale 1ns/100ps
module scs_sequencer_bench import scs_pkg::*;;
	// ==========================================================
	// Environment
	localparam int TC = 10;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	scs_cmd_type cmd = '0;
	logic adv, rst, close_out;
	scs_status_type status;
	scs_settings_type settings;
	int bad_count = 0;
	int compares = 0;
	logic [6:0] chans [3] = '{7'h01, 7'h02, 7'h41};
	always #5 clk = ~clk;
	scs_ctrl_model #(.TICK_CYCLES(TC)) ctl_u (.clk(clk), .adv(adv), .rst(rst));
	scs_sequencer #(.TICK_CYCLES(TC)) dut_u (.clk(clk), .rstn(rstn), .ce(1'b1),
		.scan_adv_pin(adv), .scan_reset_pin(rst), .cmd(cmd), .close_out(close_out),
		.status(status), .settings(settings));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	// An edge first, so back-to-back sends never write cmd twice in one step
	task automatic send(input scs_cmd_type c);
		@(posedge clk);
		#1;
		cmd = c;
		@(posedge clk);
		#1;
		cmd = '0;
	endtask : send
	task automatic trg();
		scs_cmd_type c;
		c = '0;
		c.trg = 1'b1;
		send(c);
	endtask : trg
	task automatic wait_close(output int n);
		n = 0;
		while (close_out !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("close", close_out, 1'b1);
	endtask : wait_close
	task automatic idle_ok();
		check("active", status.scan_active, 1'b0);
		check("closed", status.relay_closed, 1'b0);
		check("ptr", status.ptr, 6'h00);
	endtask : idle_ok
	// ==========================================================
	// Scenarios
	task automatic t_load();
		scs_cmd_type c;
		for (int i = 0; i < 3; i++) begin
			c = '0;
			c.wr_list = 1'b1;
			c.list_idx = 6'(i);
			c.list_chan = chans[i];
			send(c);
		end
		c = '0;
		c.wr_len = 1'b1;
		c.len = 7'h03;
		c.wr_delay = 1'b1;
		c.slot = 2'h2;
		c.delay_ms = 14'h0003;
		send(c);
		check("len", settings.list_len, 7'h03);
	endtask : t_load
	task automatic t_scan();
		int n;
		trg();
		wait_close(n);
		check("chan0", status.chan, chans[0]);
		n = 0;
		while (close_out === 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("width", (n >= 4 * TC && n <= 5 * TC), 1'b1);
		trg();
		check("ptr1", status.ptr, 6'h01);
		wait_close(n);
		check("chan1", status.chan, chans[1]);
		trg();
		check("cut", close_out, 1'b0);
		// Pin edge lands in the channel delay and must be ignored
		fork
			ctl_u.pulse(1'b0);
			wait_close(n);
		join
		check("ignore", status.ptr, 6'h02);
		check("delay", (n >= 2 * TC && n <= 3 * TC + 4), 1'b1);
		check("chan2", status.chan, chans[2]);
		repeat (20 * TC) @(posedge clk);
		#1;
		check("hold", status.relay_closed, 1'b1);
		trg();
		idle_ok();
		trg();
		wait_close(n);
		check("again", status.chan, chans[0]);
	endtask : t_scan
	task automatic t_reject();
		scs_cmd_type c;
		c = '0;
		c.wr_len = 1'b1;
		c.len = 7'h01;
		send(c);
		check("rej len", status.reject, 1'b1);
		check("len kept", settings.list_len, 7'h03);
		c = '0;
		c.wr_close = 1'b1;
		c.close_en = 1'b1;
		send(c);
		check("rej close", status.reject, 1'b1);
	endtask : t_reject
	task automatic t_pins();
		int n;
		scs_cmd_type c;
		ctl_u.pulse(1'b1);
		idle_ok();
		ctl_u.pulse(1'b0);
		wait_close(n);
		check("pin start", status.chan, chans[0]);
		c = '0;
		c.abort = 1'b1;
		send(c);
		idle_ok();
		c = '0;
		c.wr_filter = 1'b1;
		c.filt_en = 1'b1;
		c.filt_ms = 10'h003;
		c.wr_close = 1'b1;
		c.close_en = 1'b1;
		c.close_chan = 7'h05;
		send(c);
		check("manual", {status.relay_closed, status.chan}, 8'h85);
		// A pulse of about 1.2 ms is shorter than the 3 ms filter time
		ctl_u.pulse(1'b0);
		repeat (3) @(posedge clk);
		#1;
		check("filtered", status.scan_active, 1'b0);
	endtask : t_pins
	task automatic t_init();
		scs_cmd_type c;
		logic [6:0] exp [5] = '{7'h01, 7'h64, 7'h05, 7'h01, 7'h14};
		for (int i = 0; i < 5; i++) begin
			c = '0;
			c.wr_pulse = 1'b1;
			c.pw_sel = scs_pw_sel_type'(i == 4 ? 0 : (i + 1) % 4);
			c.pw_ms = (i == 4) ? 7'h14 : 7'h00;
			send(c);
			check("pw", settings.pw_ms, exp[i]);
		end
		c = '0;
		c.wr_comm = 1'b1;
		c.comm = 4'h5;
		c.wr_conn = 1'b1;
		c.conn = 1'b1;
		c.wr_shield = 1'b1;
		c.shield = 1'b1;
		send(c);
		check("comm wr", status.comm_wr, 1'b1);
		check("conn", {settings.conn, settings.shield}, 2'h3);
		c = '0;
		c.init = 1'b1;
		send(c);
		check("pw def", settings.pw_ms, 7'h05);
		check("filter", {settings.filt_en, settings.filt_ms}, 11'h032);
		check("comm", settings.comm, 4'h5);
		check("conn def", {settings.conn, settings.shield}, 2'h0);
		check("opened", status.relay_closed, 1'b0);
		c = '0;
		c.backup = 1'b1;
		send(c);
		check("backup", status.backup_wr, 1'b1);
	endtask : t_init
	// ==========================================================
	// Sequence and watchdog
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rstn = 1'b1;
		check("pw rst", settings.pw_ms, 7'h05);
		check("close rst", close_out, 1'b0);
		check("filt rst", settings.filt_en, 1'b0);
		t_load();
		t_scan();
		t_reject();
		t_pins();
		t_init();
		test_done();
	end
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule : scs_sequencer_bench
